//--- tbm_top.sv
// Timer B group: register file, prescaler and three channels
//
// Our own choice: the plain strobed port.
`timescale 1ns/1ps
module tbm_top import tbm_pkg::*; (
    input wire logic clk,
    input wire logic reset,
    input wire logic [ADDR_W-1:0] addr,
    input wire logic [DATA_W-1:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [DATA_W-1:0] rdata,
    input wire logic fast_onchip_osc,
    input wire logic slow_onchip_osc,
    input wire logic subclock_div32,
    input wire logic [NCH-1:0] event_in,
    input wire logic [NCH-1:0] meas_in,
    output logic [NCH-1:0] done
);
    logic [7:0] mode_q [NCH];
    logic [7:0] src_a_q;
    logic [7:0] src_b_q;
    logic [7:0] fsel_q;
    logic [7:0] start_q;
    logic [7:0] presc_q;
    logic [DATA_W-1:0] rdata_q;
    logic [DATA_W-1:0] rdata_d;
    logic [NSRC-1:0] src_tick;
    logic [NCH-1:0] wr_main;
    tbm_cfg_t cfg [NCH];
    tbm_view_t view [NCH];
    logic [2:0] new_src [NCH];
    logic [NCH-1:0] new_opt;
    logic [11:0] main_addr [NCH];
    logic [11:0] mode_addr [NCH];
    logic [11:0] sec_addr [NCH];

    assign main_addr = '{ADDR_MAIN0, ADDR_MAIN1, ADDR_MAIN2};
    assign mode_addr = '{ADDR_MODE0, ADDR_MODE1, ADDR_MODE2};
    assign sec_addr = '{ADDR_SEC0, ADDR_SEC1, ADDR_SEC2};

    // ****************************************
    // Register writes
    // ****************************************
    always_ff @(posedge clk) begin
        if (reset) begin
            src_a_q <= RST_BYTE;
            src_b_q <= RST_BYTE;
            fsel_q <= RST_BYTE;
            start_q <= RST_BYTE;
            presc_q <= RST_BYTE;
        end else if (wr) begin
            case (addr)
                ADDR_SRC_A: src_a_q <= wdata[7:0];
                ADDR_SRC_B: src_b_q <= wdata[7:0];
                // one select bit per channel, upper bits read zero
                ADDR_FSEL: fsel_q <= {5'h00, wdata[2:0]};
                ADDR_START: start_q <= {5'h00, wdata[2:0]};
                ADDR_PRESC: presc_q <= {7'h00, wdata[PRESC_SEL_BIT]};
                default: ;
            endcase
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < NCH; gi++) begin : g_mode
            always_ff @(posedge clk) begin
                if (reset) begin
                    mode_q[gi] <= RST_BYTE;
                end else if (wr && addr == mode_addr[gi]) begin
                    mode_q[gi] <= wdata[7:0];
                end
            end
            assign wr_main[gi] = wr && (addr == main_addr[gi]);
        end
    endgenerate

    // ****************************************
    // Per-channel configuration
    // ****************************************
    // channel 1 field bits 6..4
    // channel 2 field in second register
    assign new_src[0] = src_a_q[SRC_A_CH0_LSB +: 3];
    assign new_src[1] = src_a_q[SRC_A_CH1_LSB +: 3];
    assign new_src[2] = src_b_q[SRC_B_CH2_LSB +: 3];
    assign new_opt = {src_b_q[SRC_B_CH2_OPT], src_a_q[SRC_A_CH1_OPT], src_a_q[SRC_A_CH0_OPT]};

    generate
        for (gi = 0; gi < NCH; gi++) begin : g_ch
            assign cfg[gi] = '{
                start: start_q[gi],
                func_sel: fsel_q[gi],
                new_opt: new_opt[gi],
                new_src: new_src[gi],
                legacy: mode_q[gi][MODE_LEG_LSB +: 2],
                op: tbm_op_t'(mode_q[gi][MODE_OP_LSB +: 2]),
                mtype: mode_q[gi][MODE_MT_LSB +: 2]
            };
            tbm_chan u_chan (
                .clk(clk),
                .reset(reset),
                .cfg(cfg[gi]),
                .src_tick(src_tick),
                .event_in(event_in[gi]),
                .meas_in(meas_in[gi]),
                .wr_main(wr_main[gi]),
                .wdata(wdata),
                .view(view[gi]),
                .done_q(done[gi])
            );
        end
    endgenerate

    tbm_presc u_presc (
        .clk(clk),
        .reset(reset),
        .presc_sel(presc_q[PRESC_SEL_BIT]),
        .fast_onchip_osc(fast_onchip_osc),
        .slow_onchip_osc(slow_onchip_osc),
        .subclock_div32(subclock_div32),
        .src_tick(src_tick)
    );

    // ****************************************
    // Read path
    // ****************************************
    // Reads have no side effects anywhere; unmapped reads return zero
    always_comb begin
        rdata_d = RD_ZERO;
        case (addr)
            ADDR_SRC_A: rdata_d = {8'h00, src_a_q};
            ADDR_SRC_B: rdata_d = {8'h00, src_b_q};
            ADDR_FSEL: rdata_d = {8'h00, fsel_q};
            ADDR_START: rdata_d = {8'h00, start_q};
            ADDR_PRESC: rdata_d = {8'h00, presc_q};
            default: ;
        endcase
        for (int i = 0; i < NCH; i++) begin
            if (addr == mode_addr[i]) begin
                rdata_d = {8'h00, mode_q[i]};
            end
            // main register view depends on select bit
            if (addr == main_addr[i]) begin
                if (cfg[i].op == TBM_OP_MEAS && !fsel_q[i]) begin
                    rdata_d = view[i].reload;
                end else begin
                    rdata_d = view[i].counter;
                end
            end
            // secondary read-only, writes fall to default
            if (addr == sec_addr[i]) begin
                rdata_d = view[i].secondary;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            rdata_q <= RD_ZERO;
        end else if (rd) begin
            rdata_q <= rdata_d;
        end else begin
            rdata_q <= RD_ZERO;
        end
    end

    assign rdata = rdata_q;
endmodule

//--- tbm_pkg.sv
// Constants, types and register map of the timer B source and capture block
// Summary of operation
// - Function select bits 0..2, one per channel
// - Select 0: result in main register
// - Select 1: main reads counter, result secondary
// - Secondary result register, 16 bits, measurement only
// - Channel 0 source field bits 2..0 decode
// - Channel 1 source field bits 6..4
// - Channel 2 source field in second register
// - Channel 0 option bit 3 picks selector
// - Channel 1 option bit 7 picks selector
// - Channel 2 option bit 3 picks selector
// - Stopped write loads reload and counter
// - Counting write loads reload, and counter too if it meets an underflow or select 1 capture
// - Prescaler input: peripheral clock or fast oscillator
package tbm_pkg;

    // ****************************************
    // Register map (byte addresses)
    // ****************************************
    localparam int ADDR_W = 12;
    localparam int DATA_W = 16;
    localparam int NCH = 3;
    localparam logic [11:0] ADDR_MAIN0 = 12'h330;
    localparam logic [11:0] ADDR_MAIN1 = 12'h332;
    localparam logic [11:0] ADDR_MAIN2 = 12'h334;
    localparam logic [11:0] ADDR_MODE0 = 12'h33B;
    localparam logic [11:0] ADDR_MODE1 = 12'h33C;
    localparam logic [11:0] ADDR_MODE2 = 12'h33D;
    localparam logic [11:0] ADDR_START = 12'h320;
    localparam logic [11:0] ADDR_SEC0 = 12'h1C0;
    localparam logic [11:0] ADDR_SEC1 = 12'h1C2;
    localparam logic [11:0] ADDR_SEC2 = 12'h1C4;
    localparam logic [11:0] ADDR_FSEL = 12'h1C6;
    localparam logic [11:0] ADDR_SRC_A = 12'h1C8;
    localparam logic [11:0] ADDR_SRC_B = 12'h1C9;
    localparam logic [11:0] ADDR_PRESC = 12'h1CB;

    // ****************************************
    // Field positions and reset values
    // ****************************************
    localparam int SRC_A_CH0_LSB = 0;
    localparam int SRC_A_CH0_OPT = 3;
    localparam int SRC_A_CH1_LSB = 4;
    localparam int SRC_A_CH1_OPT = 7;
    localparam int SRC_B_CH2_LSB = 0;
    localparam int SRC_B_CH2_OPT = 3;
    localparam int MODE_OP_LSB = 0;
    localparam int MODE_MT_LSB = 2;
    localparam int MODE_LEG_LSB = 6;
    localparam int PRESC_SEL_BIT = 0;
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [15:0] RST_WORD = 16'h0000;
    localparam logic [15:0] RD_ZERO = 16'h0000;

    // ****************************************
    // Encodings
    // ****************************************
    typedef enum logic [2:0] {
        TBM_SRC_DIV1 = 3'h0,
        TBM_SRC_DIV8 = 3'h1,
        TBM_SRC_DIV32 = 3'h2,
        TBM_SRC_DIV64 = 3'h3,
        TBM_SRC_FOSC = 3'h4,
        TBM_SRC_SOSC = 3'h5,
        TBM_SRC_SUB32 = 3'h6,
        TBM_SRC_NONE = 3'h7
    } tbm_src_t;

    typedef enum logic [1:0] {
        TBM_OP_TIMER = 2'h0,
        TBM_OP_EVENT = 2'h1,
        TBM_OP_MEAS = 2'h2,
        TBM_OP_RSVD = 2'h3
    } tbm_op_t;

    // Measurement kinds: period fall-fall, period rise-rise, width any edge
    localparam logic [1:0] MT_FALL = 2'h0;
    localparam logic [1:0] MT_RISE = 2'h1;
    localparam int NSRC = 7;

    typedef struct packed {
        logic start;
        logic func_sel;
        logic new_opt;
        logic [2:0] new_src;
        logic [1:0] legacy;
        tbm_op_t op;
        logic [1:0] mtype;
    } tbm_cfg_t;

    typedef struct packed {
        logic [15:0] counter;
        logic [15:0] reload;
        logic [15:0] secondary;
    } tbm_view_t;

endpackage

//--- tbm_presc.sv
// Shared prescaler producing one-cycle count-source ticks
`timescale 1ns/1ps
module tbm_presc import tbm_pkg::*; (
    input wire logic clk,
    input wire logic reset,
    input wire logic presc_sel,
    input wire logic fast_onchip_osc,
    input wire logic slow_onchip_osc,
    input wire logic subclock_div32,
    output logic [NSRC-1:0] src_tick
);
    logic [5:0] div_q;
    logic base_tick;

    // ****************************************
    // Prescaler input select
    // ****************************************
    // base clock choice
    assign base_tick = presc_sel ? fast_onchip_osc : 1'b1;

    always_ff @(posedge clk) begin
        if (reset) begin
            div_q <= 6'h00;
        end else if (base_tick) begin
            div_q <= div_q + 6'h01;
        end
    end

    // Ticks mark the last base tick of each division period
    always_comb begin
        src_tick = '0;
        src_tick[TBM_SRC_DIV1] = base_tick;
        src_tick[TBM_SRC_DIV8] = base_tick && (div_q[2:0] == 3'h7);
        src_tick[TBM_SRC_DIV32] = base_tick && (div_q[4:0] == 5'h1F);
        src_tick[TBM_SRC_DIV64] = base_tick && (div_q == 6'h3F);
        src_tick[TBM_SRC_FOSC] = fast_onchip_osc;
        src_tick[TBM_SRC_SOSC] = slow_onchip_osc;
        src_tick[TBM_SRC_SUB32] = subclock_div32;
    end
endmodule

//--- tbm_chan.sv
// One timer B channel: source choice, counter and measurement capture
`timescale 1ns/1ps
module tbm_chan import tbm_pkg::*; (
    input wire logic clk,
    input wire logic reset,
    input tbm_cfg_t cfg,
    input wire logic [NSRC-1:0] src_tick,
    input wire logic event_in,
    input wire logic meas_in,
    input wire logic wr_main,
    input wire logic [15:0] wdata,
    output tbm_view_t view,
    output logic done_q
);
    logic [15:0] counter_q;
    logic [15:0] reload_q;
    logic [15:0] secondary_q;
    logic meas_prev_q;
    logic [2:0] sel;
    logic tick;
    logic edge_hit;

    // ****************************************
    // Count source choice
    // ****************************************
    // option bit picks new field or legacy field
    always_comb begin
        if (cfg.new_opt) begin
            sel = cfg.new_src;
        end else begin
            case (cfg.legacy)
                2'h0: sel = TBM_SRC_DIV1;
                2'h1: sel = TBM_SRC_DIV8;
                2'h2: sel = TBM_SRC_DIV32;
                default: sel = TBM_SRC_SUB32;
            endcase
        end
    end

    // code decode; code 111 simply never ticks
    // selection is combinational, counter untouched on change
    assign tick = (cfg.op == TBM_OP_EVENT) ? event_in : ((sel == TBM_SRC_NONE) ? 1'b0 : src_tick[sel]);

    always_comb begin
        case (cfg.mtype)
            MT_FALL: edge_hit = meas_prev_q && !meas_in;
            MT_RISE: edge_hit = !meas_prev_q && meas_in;
            default: edge_hit = meas_prev_q ^ meas_in;
        endcase
    end

    // ****************************************
    // Counter and capture
    // ****************************************
    always_ff @(posedge clk) begin
        if (reset) begin
            meas_prev_q <= 1'b0;
        end else begin
            meas_prev_q <= meas_in;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            counter_q <= RST_WORD;
            reload_q <= RST_WORD;
            secondary_q <= RST_WORD;
            done_q <= 1'b0;
        end else begin
            done_q <= 1'b0;
            if (wr_main) begin
                // running write goes to reload, and to counter only on a coincident underflow or select 1 capture
                reload_q <= wdata;
                if (!cfg.start) begin
                    counter_q <= wdata;
                end
            end
            if (cfg.start && cfg.op == TBM_OP_MEAS) begin
                if (edge_hit) begin
                    done_q <= 1'b1;
                    if (cfg.func_sel) begin
                        // result to secondary, counter restarts from reload
                        secondary_q <= counter_q;
                        counter_q <= wr_main ? wdata : reload_q;
                    end else begin
                        // result held where the main register reads
                        if (!wr_main) begin
                            reload_q <= counter_q;
                        end
                        counter_q <= RST_WORD;
                    end
                end else if (tick) begin
                    counter_q <= counter_q + 16'h0001;
                end
            end else if (cfg.start && tick) begin
                if (counter_q == RST_WORD) begin
                    counter_q <= wr_main ? wdata : reload_q;
                    done_q <= 1'b1;
                end else begin
                    counter_q <= counter_q - 16'h0001;
                end
            end
        end
    end

    assign view = '{counter: counter_q, reload: reload_q, secondary: secondary_q};
endmodule

//--- tbm_top_props.sv
// Checker bound to the timer B group register port
`timescale 1ns/1ps
module tbm_top_props import tbm_pkg::*; (
    input wire logic clk,
    input wire logic reset,
    input wire logic [ADDR_W-1:0] addr,
    input wire logic [DATA_W-1:0] wdata,
    input wire logic wr,
    input wire logic rd,
    input wire logic [DATA_W-1:0] rdata,
    input wire logic fast_onchip_osc,
    input wire logic slow_onchip_osc,
    input wire logic subclock_div32,
    input wire logic [NCH-1:0] event_in,
    input wire logic [NCH-1:0] meas_in,
    input wire logic [NCH-1:0] done
);
    // ********
    // Shadows
    // ********
    logic [7:0] fs_q, sa_q, sb_q;
    logic pr_q, sec_rd, is_main, srd_q;
    logic [2:0] st_q, ev_q, ok_q;
    logic [1:0] ch, ch_q;
    logic [15:0] sl_q [3];
    logic [15:0] sl_now;
    assign ch = addr[2:1];
    assign sec_rd = rd && addr inside {ADDR_SEC0, ADDR_SEC1, ADDR_SEC2};
    assign is_main = addr inside {ADDR_MAIN0, ADDR_MAIN1, ADDR_MAIN2};
    assign sl_now = sl_q[ch];
    always_ff @(posedge clk) begin
        if (reset) begin
            fs_q <= 8'h00;
            sa_q <= 8'h00;
            sb_q <= 8'h00;
            pr_q <= 1'b0;
            st_q <= 3'h0;
            ev_q <= 3'h0;
        end else if (wr) begin
            if (addr == ADDR_FSEL) begin
                fs_q <= wdata[7:0];
                ev_q <= ev_q | wdata[2:0];
            end
            if (addr == ADDR_SRC_A) sa_q <= wdata[7:0];
            if (addr == ADDR_SRC_B) sb_q <= wdata[7:0];
            if (addr == ADDR_PRESC) pr_q <= wdata[0];
            if (addr == ADDR_START) st_q <= wdata[2:0];
        end
    end
    // Seen value trusted only until a capture into it may have happened
    always_ff @(posedge clk) begin
        srd_q <= sec_rd && !reset;
        ch_q <= ch;
        if (reset) ok_q <= 3'h0;
        else ok_q <= (ok_q | ({2'b00, srd_q} << ch_q)) & ~(done & fs_q[2:0]);
        if (srd_q) sl_q[ch_q] <= rdata;
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    chk_fsel_back: assert property (rd && addr == ADDR_FSEL |=> rdata[2:0] == fs_q[2:0])
        else $error("function select readback wrong");
    chk_sec_unused: assert property (sec_rd && !ev_q[ch] |=> rdata == RD_ZERO)
        else $error("secondary not zero while unused");
    chk_srca_back: assert property (rd && addr == ADDR_SRC_A |=> rdata[7:0] == sa_q)
        else $error("source select a readback wrong");
    chk_srcb_back: assert property (rd && addr == ADDR_SRC_B |=> rdata[3:0] == sb_q[3:0])
        else $error("source select b readback wrong");
    chk_stop_load: assert property (wr && is_main && !st_q[ch] ##1 !wr ##1 rd && addr == $past(addr, 2) |=> rdata == $past(wdata, 3))
        else $error("stopped write not loaded");
    chk_presc_back: assert property (rd && addr == ADDR_PRESC |=> rdata[0] == pr_q)
        else $error("prescaler select readback wrong");
    chk_sec_hold: assert property (sec_rd && ok_q[ch] && !(done[ch] && fs_q[ch]) |=> rdata == $past(sl_now))
        else $error("secondary changed without capture");
    chk_rd_idle: assert property (!rd |=> rdata == RD_ZERO)
        else $error("read data without read strobe");
endmodule
bind tbm_top tbm_top_props u_props (.clk(clk), .reset(reset), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .fast_onchip_osc(fast_onchip_osc), .slow_onchip_osc(slow_onchip_osc),
    .subclock_div32(subclock_div32), .event_in(event_in), .meas_in(meas_in), .done(done));

//--- tb_timer_b_source_and_capture.sv
// Self-checking bench for the timer B source and capture block
`timescale 1ns/1ps
module tb_timer_b_source_and_capture import tbm_pkg::*; ();
    // ********
    // Stimulus
    // ********
    localparam int FP = 3;
    localparam int SP = 5;
    localparam int CP = 7;
    localparam int PT [7] = '{1, 8, 32, 64, FP, SP, CP};
    localparam logic [11:0] RA [11] = '{ADDR_SEC0, ADDR_SEC1, ADDR_SEC2, ADDR_FSEL, ADDR_SRC_A, ADDR_SRC_B,
        ADDR_PRESC, ADDR_MAIN0, ADDR_MAIN1, ADDR_MAIN2, 12'h1CA};
    logic clk = 1'b0, reset = 1'b1, wr = 1'b0, rd = 1'b0;
    logic [11:0] addr = 12'h000;
    logic [15:0] wdata = 16'h0000;
    logic [15:0] rdata, v, a;
    logic fast_onchip_osc = 1'b0, slow_onchip_osc = 1'b0, subclock_div32 = 1'b0;
    logic [2:0] event_in = 3'h0, meas_in = 3'h0, done;
    int failures = 0, checks_done = 0, tk = 0, n;
    tbm_top u_dut (.clk(clk), .reset(reset), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
        .fast_onchip_osc(fast_onchip_osc), .slow_onchip_osc(slow_onchip_osc), .subclock_div32(subclock_div32),
        .event_in(event_in), .meas_in(meas_in), .done(done));
    initial begin
        forever #25 clk = ~clk;
    end
    // Oscillator ticks at fixed, distinct spacings
    always @(posedge clk) begin
        tk <= tk + 1;
        fast_onchip_osc <= tk % FP == 0;
        slow_onchip_osc <= tk % SP == 0;
        subclock_div32 <= tk % CP == 0;
    end
    task automatic summarize();
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        checks_done++;
        if (g !== e) begin
            failures++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic wreg(input logic [11:0] ad, input logic [15:0] d);
        @(posedge clk);
        addr <= ad;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rreg(input logic [11:0] ad);
        @(posedge clk);
        addr <= ad;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        @(negedge clk);
        v = rdata;
    endtask
    task automatic wdone(input int c);
        n = 0;
        do begin
            @(negedge clk);
            n++;
        end while (done[c] !== 1'b1 && n < 3000);
    endtask
    // Reload 1 gives two ticks per underflow, so the period is twice the tick spacing
    task automatic tmr(input int c, input logic [2:0] code, input logic opt, input logic [1:0] leg, input int e);
        logic [15:0] s;
        s = c == 1 ? {8'h00, opt, code, 4'h0} : {12'h000, opt, code};
        wreg(ADDR_MODE0 + 12'(c), {8'h00, leg, 6'h00});
        wreg(c == 2 ? ADDR_SRC_B : ADDR_SRC_A, s);
        wreg(ADDR_MAIN0 + 12'(2 * c), 16'h0001);
        wreg(ADDR_START, 16'h0001 << c);
        wdone(c);
        wdone(c);
        chk("underflow period", 16'(e), 16'(n));
        wreg(ADDR_START, 16'h0000);
    endtask
    task automatic fall();
        @(posedge clk);
        meas_in <= 3'h3;
        repeat (4) @(posedge clk);
        meas_in <= 3'h0;
        repeat (4) @(posedge clk);
    endtask
    initial begin
        repeat (8) @(posedge clk);
        reset <= 1'b0;
        for (int i = 0; i < 11; i++) begin
            rreg(RA[i]);
            chk("reset value", 16'h0000, v);
        end
        wreg(ADDR_SEC1, 16'hA5A5);
        rreg(ADDR_SEC1);
        chk("secondary write", 16'h0000, v);
        wreg(ADDR_FSEL, 16'h0007);
        rreg(ADDR_FSEL);
        chk("function select", 16'h0007, v & 16'h0007);
        wreg(ADDR_SRC_A, 16'h00ED);
        rreg(ADDR_SRC_A);
        chk("source select a", 16'h00ED, v & 16'h00FF);
        wreg(ADDR_SRC_B, 16'h000C);
        rreg(ADDR_SRC_B);
        chk("source select b", 16'h000C, v & 16'h000F);
        wreg(ADDR_FSEL, 16'h0000);
        for (int c = 0; c < 7; c++) begin
            tmr(0, 3'(c), 1'b1, 2'h0, 2 * PT[c]);
        end
        tmr(1, 3'h3, 1'b1, 2'h0, 128);
        tmr(1, 3'h3, 1'b0, 2'h1, 16);
        tmr(2, 3'h5, 1'b1, 2'h0, 2 * SP);
        tmr(2, 3'h5, 1'b0, 2'h3, 2 * CP);
        tmr(0, 3'h1, 1'b0, 2'h2, 64);
        wreg(ADDR_PRESC, 16'h0001);
        rreg(ADDR_PRESC);
        chk("prescaler select", 16'h0001, v & 16'h0001);
        tmr(0, 3'h0, 1'b1, 2'h0, 2 * FP);
        tmr(0, 3'h1, 1'b1, 2'h0, 16 * FP);
        wreg(ADDR_PRESC, 16'h0000);
        for (int c = 0; c < 3; c++) begin
            wreg(ADDR_MAIN0 + 12'(2 * c), 16'h0055 + 16'(c));
            rreg(ADDR_MAIN0 + 12'(2 * c));
            chk("stopped load", 16'h0055 + 16'(c), v);
        end
        wreg(ADDR_FSEL, 16'h0001);
        wreg(ADDR_SRC_A, 16'h0000);
        wreg(ADDR_MODE0, 16'h0002);
        wreg(ADDR_MODE1, 16'h0002);
        wreg(ADDR_MAIN0, 16'h0100);
        wreg(ADDR_MAIN1, 16'h0100);
        wreg(ADDR_START, 16'h0003);
        fall();
        fall();
        rreg(ADDR_MAIN0);
        a = v;
        rreg(ADDR_MAIN0);
        chk("counter moves", 16'h0001, 16'(v !== a));
        chk("counter base", 16'h0100, v & 16'hFF00);
        rreg(ADDR_SEC0);
        a = v;
        chk("result stored", 16'h0100, a & 16'hFF00);
        rreg(ADDR_SEC0);
        chk("result stable", a, v);
        rreg(ADDR_MAIN1);
        a = v;
        rreg(ADDR_MAIN1);
        chk("result in main", a, v);
        rreg(ADDR_SEC1);
        chk("secondary unused", 16'h0000, v);
        wreg(ADDR_MAIN0, 16'h0300);
        rreg(ADDR_MAIN0);
        chk("reload only", 16'h0100, v & 16'hFF00);
        wreg(ADDR_SRC_A, 16'h0009);
        rreg(ADDR_MAIN0);
        chk("source change", 16'h0100, v & 16'hFF00);
        fall();
        rreg(ADDR_MAIN0);
        chk("next reload", 16'h0300, v & 16'hFF00);
        summarize();
    end
    initial begin
        repeat (40000) @(posedge clk);
        failures++;
        summarize();
    end
endmodule
